// *** design/somon_defs.vh ***
`ifndef SOMON_DEFS_VH
`define SOMON_DEFS_VH
// clock rate
`define SOMON_CLK_HZ            100000000
// mismatch timeout, about one second, in ms
`define SOMON_MISMATCH_MS       1000
// enable-without-travel timeout, in ms
`define SOMON_NOTRAVEL_MS       2500
// switch-off deadline on mismatch, in ms
`define SOMON_SWITCHOFF_MAX_MS  1600
// cycles per millisecond tick
`define SOMON_TICK_CYC          (`SOMON_CLK_HZ / 1000)
// fault codes
`define SOMON_CODE_NONE         10'h000
`define SOMON_CODE_MISMATCH     10'h3C0
`define SOMON_CODE_NOTRAVEL     10'h15D
// register addresses
`define SOMON_ADDR_STATUS       4'h0
`define SOMON_ADDR_CODE         4'h4
`define SOMON_ADDR_CTRL         4'h8
// status bit positions
`define SOMON_ST_CHA            0
`define SOMON_ST_CHB            1
`define SOMON_ST_DIAGNOSTIC_HEALTHY_INDICATION           2
`define SOMON_ST_MISMATCH       3
`define SOMON_ST_NOTRAVEL       4
`define SOMON_ST_ENABLE         5
`define SOMON_ST_SAFEOFF        6
// ctrl bit positions and reset
`define SOMON_CT_INFO_EN        0
`define SOMON_CTRL_RST          32'h0000_0001
// axi responses
`define SOMON_RESP_OKAY         2'b00
`define SOMON_RESP_SLVERR       2'b10
`endif

// *** design/somon_tick.v ***
`timescale 1ns/10ps
`include "somon_defs.vh"
// one-cycle enable pulse every DIV clock cycles
module somon_tick #(
   parameter DIV = `SOMON_TICK_CYC
) (
   input  wire ref_clk_i,
   input  wire rst_b_i,
   output reg  tick_o
);
   reg [31:0] cnt_r;

   // free-running divider
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         cnt_r  <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (cnt_r >= DIV - 1) begin
         cnt_r  <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h0000_0001;
         tick_o <= 1'b0;
      end
   end
endmodule // somon_tick

// *** design/somon_top.v ***
// Functional notes
// - Channel A alone at standstill shows A and healthy, then after about a second clears both and latches mismatch fault 960.
// - Channel B alone at standstill shows B and healthy, then after about a second clears both and latches mismatch fault 960.
// - While one channel alone is active and the timeout has not run out, healthy stays active.
// - The mismatch fault holds until power is cycled; releasing the channel does not clear it.
// - Both channels active at standstill without travel for 2.5 s raises fault 349.
// - At standstill with both channels off and no fault, both channel indications are off and healthy is on.
// - Output-stage switching is allowed only while both channels are active.
// - On unequal channels the drive is switched off within 1600 ms and stays off until power cycle.
// - The safe-off state is optionally reported on a non-safety status output.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "somon_defs.vh"
module somon_top #(
   parameter MISMATCH_MS = `SOMON_MISMATCH_MS,
   parameter NOTRAVEL_MS = `SOMON_NOTRAVEL_MS,
   parameter TICK_CYC    = `SOMON_TICK_CYC
) (
   input  wire        ref_clk_i,
   input  wire        rst_b_i,
   input  wire        safe_off_channel_a_i,
   input  wire        safe_off_channel_b_i,
   input  wire        travel_cmd_i,
   output reg         chan_a_ind_o,
   output reg         chan_b_ind_o,
   output reg         diagnostic_healthy_indication_o,
   output reg         channel_mismatch_fault_o,
   output reg         enable_without_travel_fault_o,
   output reg  [9:0]  fault_code_o,
   output reg         stage_enable_o,
   output reg         safe_off_status_output_o,
   // axi4-lite slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   // supervisor states
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_ONE   = 2'b01;
   localparam [1:0] ST_BOTH  = 2'b10;
   localparam [1:0] ST_FAULT = 2'b11;

   // timeout test shared by both supervised conditions; the tick runs
   // free, so a timeout may end up to one tick early, which the 1000 ms
   // choice absorbs well inside the 1600 ms switch-off bound
   function somon_expired;
      input        tk;
      input [11:0] cnt;
      input integer lim;
      begin
         somon_expired = tk && (cnt >= lim - 1);
      end
   endfunction

   // input stage, supervisor state and bus bookkeeping
   reg        cha_r;
   reg        chb_r;
   reg        trv_r;
   reg [1:0]  state_r;
   reg [1:0]  state_nxt;
   reg [11:0] ms_cnt_r;
   reg [11:0] ms_cnt_nxt;
   reg        mis_lat_r;
   reg        ewt_lat_r;
   reg [31:0] ctrl_r;
   reg        aw_got_r;
   reg        w_got_r;
   reg [3:0]  aw_addr_r;
   wire       tick;
   wire       one_only;
   wire       both_on;
   wire       run_ok;

   // ms tick keeps the counters narrow: twelve bits cover the longest
   // limit, where counting raw clocks would need 28
   somon_tick #(
      .DIV (TICK_CYC)
   ) u_tick (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .tick_o    (tick)
   );

   // one register stage; the pins are taken as synchronous already
   // input sampling register
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         cha_r <= 1'b0;
         chb_r <= 1'b0;
         trv_r <= 1'b0;
      end else begin
         cha_r <= safe_off_channel_a_i;
         chb_r <= safe_off_channel_b_i;
         trv_r <= travel_cmd_i;
      end
   end

   // channel patterns seen by the supervisor
   assign one_only = cha_r ^ chb_r;
   assign both_on  = cha_r & chb_r;
   // outputs follow the registered state, so indications, fault flags
   // and the stage permit all change on one edge
   assign run_ok   = (state_r != ST_FAULT);

   // supervision state machine; ms_cnt counts elapsed milliseconds
   always @* begin
      state_nxt  = state_r;
      ms_cnt_nxt = ms_cnt_r;
      case (state_r)
         ST_IDLE: begin
            // held at zero so every episode gets a full timeout
            ms_cnt_nxt = 12'h000;
            if (one_only)
               state_nxt = ST_ONE;
            else if (both_on && !trv_r)
               state_nxt = ST_BOTH;
         end
         ST_ONE: begin
            // a dropped channel, or both up, ends the episode
            // single-channel timing
            // mismatch timeout well inside 1600 ms
            if (somon_expired(tick, ms_cnt_r, MISMATCH_MS)) begin
               state_nxt = ST_FAULT;
            end else if (!one_only) begin
               state_nxt  = ST_IDLE;
               ms_cnt_nxt = 12'h000;
            end else if (tick) begin
               ms_cnt_nxt = ms_cnt_r + 12'h001;
            end
         end
         ST_BOTH: begin
            // travel, or a dropped channel, restarts the timer
            // enable without travel timing
            if (somon_expired(tick, ms_cnt_r, NOTRAVEL_MS)) begin
               state_nxt = ST_FAULT;
            end else if (!both_on || trv_r) begin
               state_nxt  = ST_IDLE;
               ms_cnt_nxt = 12'h000;
            end else if (tick) begin
               ms_cnt_nxt = ms_cnt_r + 12'h001;
            end
         end
         ST_FAULT: begin
            // no input pattern can leave; only a power cycle clears
            // only reset leaves here
            state_nxt = ST_FAULT;
         end
         default: begin
            // all four codes are used; kept as a safe fallback
            state_nxt  = ST_IDLE;
            ms_cnt_nxt = 12'h000;
         end
      endcase
   end

   // state and fault latches; the latches only ever set, and reset,
   // standing in for a power cycle, is their one clear
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         state_r   <= ST_IDLE;
         ms_cnt_r  <= 12'h000;
         mis_lat_r <= 1'b0;
         ewt_lat_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         ms_cnt_r <= ms_cnt_nxt;
         if (state_r == ST_ONE && state_nxt == ST_FAULT)
            mis_lat_r <= 1'b1;
         if (state_r == ST_BOTH && state_nxt == ST_FAULT)
            ewt_lat_r <= 1'b1;
      end
   end

   // registered outputs; a latched fault forces every indication low
   // and removes the stage permit
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         chan_a_ind_o                    <= 1'b0;
         chan_b_ind_o                    <= 1'b0;
         diagnostic_healthy_indication_o <= 1'b0;
         channel_mismatch_fault_o        <= 1'b0;
         enable_without_travel_fault_o   <= 1'b0;
         fault_code_o                    <= `SOMON_CODE_NONE;
         stage_enable_o                  <= 1'b0;
         safe_off_status_output_o        <= 1'b0;
      end else begin
         chan_a_ind_o <= cha_r & run_ok;
         chan_b_ind_o <= chb_r & run_ok;
         diagnostic_healthy_indication_o <= run_ok;
         // the fault flags rise on the edge that drops the indications
         channel_mismatch_fault_o <= mis_lat_r;
         enable_without_travel_fault_o <= ewt_lat_r;
         // mismatch code wins if both faults were ever latched
         if (mis_lat_r)
            fault_code_o <= `SOMON_CODE_MISMATCH;
         else if (ewt_lat_r)
            fault_code_o <= `SOMON_CODE_NOTRAVEL;
         else
            fault_code_o <= `SOMON_CODE_NONE;
         // switching needs both channels and no fault
         stage_enable_o <= both_on & run_ok;
         safe_off_status_output_o <= ctrl_r[`SOMON_CT_INFO_EN] &
                                     ~(both_on & run_ok);
      end
   end

   // write channel: address and data taken in either order; both readies
   // stay low while a response waits, so a second write cannot overrun
   // the response the master has not yet taken
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_r && !s_axi_bvalid;

   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         aw_addr_r    <= 4'h0;
         ctrl_r       <= `SOMON_CTRL_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SOMON_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
            w_got_r <= 1'b1;
         if (aw_got_r && w_got_r && !s_axi_bvalid) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // only ctrl is writable; others answer slverr
            if (aw_addr_r == `SOMON_ADDR_CTRL) begin
               s_axi_bresp <= `SOMON_RESP_OKAY;
               // only the low byte lane carries a writable bit
               if (s_axi_wstrb[0])
                  ctrl_r[`SOMON_CT_INFO_EN] <= s_axi_wdata[0];
            end else begin
               s_axi_bresp <= `SOMON_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one read at a time; the status word is a snapshot
   // of the registered outputs
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SOMON_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `SOMON_RESP_OKAY;
         case (s_axi_araddr)
            `SOMON_ADDR_STATUS:
               s_axi_rdata <= {25'h000_0000, safe_off_status_output_o,
                               stage_enable_o,
                               enable_without_travel_fault_o,
                               channel_mismatch_fault_o,
                               diagnostic_healthy_indication_o,
                               chan_b_ind_o, chan_a_ind_o};
            `SOMON_ADDR_CODE:
               s_axi_rdata <= {22'h00_0000, fault_code_o};
            `SOMON_ADDR_CTRL:
               s_axi_rdata <= ctrl_r;
            default: begin
               // unmapped reads return zero with an error response
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `SOMON_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // somon_top

// *** sim/somon_assertions.sv ***
`timescale 1ns/10ps
`include "somon_defs.vh"
module somon_checker #(
   parameter MISMATCH_MS = `SOMON_MISMATCH_MS,
   parameter NOTRAVEL_MS = `SOMON_NOTRAVEL_MS,
   parameter TICK_CYC    = `SOMON_TICK_CYC
) (
   input wire       ref_clk_i,
   input wire       rst_b_i,
   input wire       travel_cmd_i,
   input wire       chan_a_ind_o,
   input wire       chan_b_ind_o,
   input wire       diagnostic_healthy_indication_o,
   input wire       channel_mismatch_fault_o,
   input wire       enable_without_travel_fault_o,
   input wire [9:0] fault_code_o,
   input wire       stage_enable_o
);
   wire       mm = channel_mismatch_fault_o;
   wire       nt = enable_without_travel_fault_o;
   wire       one = (chan_a_ind_o ^ chan_b_ind_o) & ~mm & ~nt;
   wire       two = chan_a_ind_o & chan_b_ind_o & ~travel_cmd_i & ~mm & ~nt;
   reg [31:0] one_r;
   reg [31:0] two_r;
   // run lengths seen through the indications, so a few cycles of slack
   always @(posedge ref_clk_i) begin
      one_r <= (rst_b_i & one) ? one_r + 32'h0000_0001 : 32'h0000_0000;
      two_r <= (rst_b_i & two) ? two_r + 32'h0000_0001 : 32'h0000_0000;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // mismatch fault has just latched
   sequence mm_rise;
      $rose(mm);
   endsequence
   fault_code_a: assert property (mm |-> fault_code_o == 10'h3C0)
      else $error("mismatch code wrong");
   mm_hold_a: assert property (mm |=> mm)
      else $error("mismatch fault dropped");
   nt_hold_a: assert property (nt |=> nt)
      else $error("no-travel fault dropped");
   stage_pair_a: assert property (stage_enable_o |-> chan_a_ind_o &&
      chan_b_ind_o && !mm && !nt) else $error("stage enabled wrongly");
   healthy_a: assert property ($past(rst_b_i) |->
      diagnostic_healthy_indication_o == !(mm || nt))
      else $error("healthy indication wrong");
   mm_cause_a: assert property (mm_rise |->
      $past(chan_a_ind_o ^ chan_b_ind_o) &&
      one_r >= (MISMATCH_MS - 1) * TICK_CYC - 6)
      else $error("mismatch raised early");
   mm_deadline_a: assert property (
      one_r <= (MISMATCH_MS + 1) * TICK_CYC + 8)
      else $error("mismatch raised late");
   nt_deadline_a: assert property (
      two_r <= (NOTRAVEL_MS + 1) * TICK_CYC + 8)
      else $error("no-travel fault late");
endmodule // somon_checker
bind somon_top somon_checker #(.MISMATCH_MS(MISMATCH_MS),
   .NOTRAVEL_MS(NOTRAVEL_MS), .TICK_CYC(TICK_CYC)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .travel_cmd_i(travel_cmd_i),
   .chan_a_ind_o(chan_a_ind_o), .chan_b_ind_o(chan_b_ind_o),
   .diagnostic_healthy_indication_o(diagnostic_healthy_indication_o),
   .channel_mismatch_fault_o(channel_mismatch_fault_o),
   .enable_without_travel_fault_o(enable_without_travel_fault_o),
   .fault_code_o(fault_code_o), .stage_enable_o(stage_enable_o));

// *** sim/somon_relays.sv ***
`timescale 1ns/10ps
module somon_relays #(
   parameter DLY = 2
) (
   input  wire ref_clk_i,
   input  wire coil_a_i,
   input  wire coil_b_i,
   output wire contact_a_o,
   output wire contact_b_o
);
   reg [7:0] a_r = 8'h00;
   reg [7:0] b_r = 8'h00;
   // pickup and drop-out delay only; contact bounce is not modelled
   always @(posedge ref_clk_i) begin
      a_r <= {a_r[6:0], coil_a_i};
      b_r <= {b_r[6:0], coil_b_i};
   end
   assign contact_a_o = a_r[DLY];
   assign contact_b_o = b_r[DLY];
endmodule // somon_relays

// *** sim/tb_safe_off_channel_monitor.sv ***
`timescale 1ns/10ps
`include "somon_defs.vh"
module tb_safe_off_channel_monitor;
   localparam MM = 5;
   localparam NT = 12;
   localparam TK = 10;
   reg          ref_clk_i = 1'b0, rst_b_i = 1'b0, travel = 1'b0;
   reg          coil_a = 1'b0, coil_b = 1'b0;
   reg  [3:0]   awaddr = 4'h0, araddr = 4'h0;
   reg  [31:0]  wdata = 32'h0;
   reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   reg          arvalid = 1'b0, rready = 1'b0;
   wire         ch_a, ch_b, ia, ib, hl, mm, nt, se, so;
   wire         awready, wready, bvalid, arready, rvalid;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [9:0]   code;
   int          bad_count = 0, n_checks = 0, k, ch;
   logic [31:0] rd;
   logic [1:0]  rs;

   somon_relays #(.DLY(2)) u_rel (.ref_clk_i(ref_clk_i), .coil_a_i(coil_a),
      .coil_b_i(coil_b), .contact_a_o(ch_a), .contact_b_o(ch_b));
   somon_top #(.MISMATCH_MS(MM), .NOTRAVEL_MS(NT), .TICK_CYC(TK)) DUT (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .safe_off_channel_a_i(ch_a),
      .safe_off_channel_b_i(ch_b), .travel_cmd_i(travel), .chan_a_ind_o(ia),
      .chan_b_ind_o(ib), .diagnostic_healthy_indication_o(hl),
      .channel_mismatch_fault_o(mm), .enable_without_travel_fault_o(nt),
      .fault_code_o(code), .stage_enable_o(se), .safe_off_status_output_o(so),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // 100 MHz clock
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task final_report;
      begin
         if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         n_checks++;
         if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // sample at the falling edge, where every output has settled
   task pins(input logic [6:0] e, input logic [9:0] c);
      begin
         @(negedge ref_clk_i);
         chk("pins", {25'h0, e}, {25'h0, so, se, nt, mm, hl, ib, ia});
         chk("code", {22'h0, c}, {22'h0, code});
         @(posedge ref_clk_i);
      end
   endtask

   // power cycle: the only way out of a latched fault
   task pwr;
      begin
         rst_b_i <= 1'b0;
         coil_a <= 1'b0;
         coil_b <= 1'b0;
         travel <= 1'b0;
         repeat (8) @(posedge ref_clk_i);
         rst_b_i <= 1'b1;
         @(posedge ref_clk_i);
      end
   endtask

   task wfault;
      begin
         for (k = 0; k < 300 && !(mm | nt); k++) @(negedge ref_clk_i);
         if (k == 300) begin
            bad_count++;
            $display("Error fault wait expected fault seen none");
            final_report;
         end else begin
            @(posedge ref_clk_i);
         end
      end
   endtask

   // one axi4-lite access; handshakes judged from pre-edge values
   task axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, tr, dn;
      begin
         dn = 1'b0;
         awaddr <= a;
         araddr <= a;
         wdata <= d;
         awvalid <= wr;
         wvalid <= wr;
         bready <= wr;
         arvalid <= !wr;
         rready <= !wr;
         for (k = 0; k < 50 && !dn; k++) begin
            @(negedge ref_clk_i);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tr = arvalid & arready;
            dn = wr ? bvalid : rvalid;
            rs = wr ? bresp : rresp;
            rd = rdata;
            @(posedge ref_clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (dn) bready <= 1'b0;
            if (dn) rready <= 1'b0;
         end
         if (!dn) begin
            bad_count++;
            $display("Error bus answer expected valid seen none");
            final_report;
         end else begin
            // let one edge pass so the next call never re-raises a strobe
            @(posedge ref_clk_i);
         end
      end
   endtask

   initial begin
      @(posedge ref_clk_i);
      pwr;
      pins(7'h44, `SOMON_CODE_NONE);
      axi(1'b0, `SOMON_ADDR_CTRL, 32'h0);
      chk("ctrl", `SOMON_CTRL_RST, rd);
      axi(1'b0, 4'hC, 32'h0);
      chk("unmapped", {30'h0, `SOMON_RESP_SLVERR}, {30'h0, rs});
      chk("unmapped rd", 32'h0000_0000, rd);
      axi(1'b1, `SOMON_ADDR_STATUS, 32'h7F);
      chk("status wr", {30'h0, `SOMON_RESP_SLVERR}, {30'h0, rs});
      // one relay contact bridged, a then b
      for (ch = 0; ch < 2; ch++) begin
         pwr;
         coil_a <= (ch == 0);
         coil_b <= (ch == 1);
         repeat (6) @(posedge ref_clk_i);
         pins(ch ? 7'h46 : 7'h45, `SOMON_CODE_NONE);
         repeat ((MM - 1) * TK - 16) @(posedge ref_clk_i);
         pins(ch ? 7'h46 : 7'h45, `SOMON_CODE_NONE);
         wfault;
         pins(7'h48, `SOMON_CODE_MISMATCH);
         coil_a <= 1'b0;
         coil_b <= 1'b0;
         repeat (6) @(posedge ref_clk_i);
         pins(7'h48, `SOMON_CODE_MISMATCH);
         axi(1'b0, `SOMON_ADDR_CODE, 32'h0);
         chk("code reg", {22'h0, `SOMON_CODE_MISMATCH}, rd);
         axi(1'b1, `SOMON_ADDR_CTRL, 32'h0);
         chk("ctrl wr", {30'h0, `SOMON_RESP_OKAY}, {30'h0, rs});
         axi(1'b0, `SOMON_ADDR_CTRL, 32'h0);
         chk("ctrl rd", 32'h0000_0000, rd);
         repeat (3) @(posedge ref_clk_i);
         pins(7'h08, `SOMON_CODE_MISMATCH);
      end
      // travel holds off the no-travel timer
      pwr;
      travel <= 1'b1;
      coil_a <= 1'b1;
      coil_b <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      pins(7'h27, `SOMON_CODE_NONE);
      repeat ((NT + 2) * TK) @(posedge ref_clk_i);
      pins(7'h27, `SOMON_CODE_NONE);
      coil_a <= 1'b0;
      coil_b <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      pins(7'h44, `SOMON_CODE_NONE);
      coil_a <= 1'b1;
      coil_b <= 1'b1;
      travel <= 1'b0;
      repeat ((NT - 1) * TK - 10) @(posedge ref_clk_i);
      pins(7'h27, `SOMON_CODE_NONE);
      wfault;
      pins(7'h50, `SOMON_CODE_NOTRAVEL);
      final_report;
   end

   // cut a hang short
   initial begin
      #200_000;
      bad_count++;
      $display("Error run time expected end seen timeout");
      final_report;
   end
endmodule // tb_safe_off_channel_monitor
